// ### core/ilmp_ctrl.sv
// system-level interrupt control: enable, mask, priority resolve
`timescale 1ns/1ps
`include "ilmp_defs.svh"

// Contract
// - mode bit 0 is global enable; on-instruction sets, off-instruction clears it
// - reset clears global and fast enable; fast level field left unspecified
// - direct register write may also set or clear global enable
// - level mask register at dd has no defined reset contents
// - mask bit n zero blocks level n, one lets it through
// - mask register reads back the last written value
// - priority register at ff, bank 0, has no defined reset contents
// - highest configured level served first; within level, fixed source order
// - levels 0 and 1 form group a; 5, 6, 7 form group c
// - priority bits 7, 4, 1 order groups; 001 is b>c>a, 101 c>b>a
// - priority bit 5 orders group c; bit 6 orders its subgroup
// - priority bit 0 decides between level 0 and level 1
// - each level request also gated by its source-side enable
// - group b holds levels 2, 3 and 4
// - acknowledge needs global enable, mask, top priority and source enable
// - acknowledge clears global enable; handler return sets it again
module ilmp_ctrl
    import ilmp_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_bank_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic global_irq_on_instr_in,
    input wire logic global_irq_off_instr_in,
    input wire logic handler_return_instr_in,
    input wire logic irq_ack_in,
    input wire logic [7:0] level_req_in,
    input wire logic [7:0] level_src_en_in,
    output logic [7:0] reg_rdata_out,
    output logic irq_req_out,
    output logic [2:0] irq_level_out,
    output logic irq_fast_out,
    output logic [7:0] level_live_out
);

    ilmp_byte_t mask_ff;
    ilmp_byte_t prio_ff;
    logic gie_ff;
    logic fie_ff;
    ilmp_lvl_t fsel_ff;
    ilmp_byte_t rdata_ff;
    logic irq_req_ff;
    ilmp_lvl_t irq_level_ff;
    logic irq_fast_ff;
    ilmp_byte_t level_live_ff;

    wire hit_mask;
    wire hit_mode;
    wire hit_prio;
    wire wr_mask;
    wire wr_mode;
    wire wr_prio;
    wire ilmp_byte_t mode_view;
    wire ilmp_byte_t rd_mux;
    wire nxt_gie;
    wire ilmp_byte_t live;
    wire [2:0] gcode;
    ilmp_grp_e g_first;
    ilmp_grp_e g_second;
    ilmp_grp_e g_third;
    logic [2:0] grp_vld;
    ilmp_lvl_t grp_lvl [3];
    wire win_vld;
    wire ilmp_lvl_t win_lvl;
    wire nxt_fast;

    // register decode; priority register only answers in bank 0
    assign hit_mask = (reg_addr_in == `ILMP_OFS_MASK);
    assign hit_mode = (reg_addr_in == `ILMP_OFS_MODE);
    assign hit_prio = (reg_addr_in == `ILMP_OFS_PRIO) && (reg_bank_in == `ILMP_PRIO_BANK);
    assign wr_mask = reg_wr_in && hit_mask;
    assign wr_mode = reg_wr_in && hit_mode;
    assign wr_prio = reg_wr_in && hit_prio;

    // upper mode bits serve an external bus not built here; they read zero
    assign mode_view = {`ILMP_RSVD_MODE, fsel_ff, fie_ff, gie_ff};
    assign rd_mux = hit_mask ? mask_ff :
                    hit_mode ? mode_view :
                    hit_prio ? prio_ff :
                    `ILMP_RST_BYTE;

    // acknowledge wins: the interrupt cycle sits between instructions anyway
    assign nxt_gie = irq_ack_in ? 1'b0 :
                     global_irq_off_instr_in ? 1'b0 :
                     (global_irq_on_instr_in || handler_return_instr_in) ? 1'b1 :
                     wr_mode ? reg_wdata_in[`ILMP_MODE_GIE] :
                     gie_ff;

    // a level is live only with request, source enable and mask bit all set
    assign live = level_req_in & level_src_en_in & mask_ff;

    // group order from bits 7, 4, 1; undefined codes fall back to a>b>c
    assign gcode = {prio_ff[`ILMP_PRIO_GRP_HI], prio_ff[`ILMP_PRIO_GRP_MID],
                    prio_ff[`ILMP_PRIO_GRP_LO]};

    always_comb
    begin
        g_first = ilmp_grp_a;
        g_second = ilmp_grp_b;
        unique case (gcode)
            `ILMP_GORD_BCA:
            begin
                g_first = ilmp_grp_b;
                g_second = ilmp_grp_c;
            end
            `ILMP_GORD_BAC:
            begin
                g_first = ilmp_grp_b;
                g_second = ilmp_grp_a;
            end
            `ILMP_GORD_CAB:
            begin
                g_first = ilmp_grp_c;
                g_second = ilmp_grp_a;
            end
            `ILMP_GORD_CBA:
            begin
                g_first = ilmp_grp_c;
                g_second = ilmp_grp_b;
            end
            `ILMP_GORD_ACB:
            begin
                g_first = ilmp_grp_a;
                g_second = ilmp_grp_c;
            end
            default:
            begin
                g_first = ilmp_grp_a;
                g_second = ilmp_grp_b;
            end
        endcase
        g_third = ilmp_grp_e'(2'(`ILMP_GRP_SUM - g_first - g_second));
    end

    // group a: levels 0 and 1 only, bit 0 swaps them
    ilmp_grp_pick #(
        .LVL_SINGLE(`ILMP_LVL0),
        .LVL_PAIR_HI(`ILMP_LVL1),
        .LVL_PAIR_LO(`ILMP_LVL0)
    ) u_grp_a (
        .single_req_in(1'b0),
        .pair_hi_req_in(live[1]),
        .pair_lo_req_in(live[0]),
        .pair_first_in(1'b1),
        .pair_swap_in(prio_ff[`ILMP_PRIO_A_SWAP]),
        .win_vld_out(grp_vld[ilmp_grp_a]),
        .win_lvl_out(grp_lvl[ilmp_grp_a])
    );

    // group b: level 2 against pair 3/4
    ilmp_grp_pick #(
        .LVL_SINGLE(`ILMP_LVL2),
        .LVL_PAIR_HI(`ILMP_LVL4),
        .LVL_PAIR_LO(`ILMP_LVL3)
    ) u_grp_b (
        .single_req_in(live[2]),
        .pair_hi_req_in(live[4]),
        .pair_lo_req_in(live[3]),
        .pair_first_in(prio_ff[`ILMP_PRIO_B_ORDER]),
        .pair_swap_in(prio_ff[`ILMP_PRIO_B_SWAP]),
        .win_vld_out(grp_vld[ilmp_grp_b]),
        .win_lvl_out(grp_lvl[ilmp_grp_b])
    );

    // group c: level 5 against subgroup 6/7
    ilmp_grp_pick #(
        .LVL_SINGLE(`ILMP_LVL5),
        .LVL_PAIR_HI(`ILMP_LVL7),
        .LVL_PAIR_LO(`ILMP_LVL6)
    ) u_grp_c (
        .single_req_in(live[5]),
        .pair_hi_req_in(live[7]),
        .pair_lo_req_in(live[6]),
        .pair_first_in(prio_ff[`ILMP_PRIO_C_ORDER]),
        .pair_swap_in(prio_ff[`ILMP_PRIO_C_SWAP]),
        .win_vld_out(grp_vld[ilmp_grp_c]),
        .win_lvl_out(grp_lvl[ilmp_grp_c])
    );

    // first live group in configured order wins; one level per cycle
    assign win_vld = |grp_vld;
    assign win_lvl = grp_vld[g_first] ? grp_lvl[g_first] :
                     grp_vld[g_second] ? grp_lvl[g_second] :
                     grp_lvl[g_third];
    assign nxt_fast = fie_ff && (fsel_ff == win_lvl);

    // mask and priority have no defined reset state; zero keeps sim clean
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            mask_ff <= `ILMP_RST_BYTE;
            prio_ff <= `ILMP_RST_BYTE;
        end
        else
        begin
            if (wr_mask)
                mask_ff <= reg_wdata_in;
            if (wr_prio)
                prio_ff <= reg_wdata_in;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            gie_ff <= 1'b0;
            fie_ff <= 1'b0;
            fsel_ff <= `ILMP_RST_FSEL;
        end
        else
        begin
            gie_ff <= nxt_gie;
            if (wr_mode)
            begin
                fie_ff <= reg_wdata_in[`ILMP_MODE_FIE];
                fsel_ff <= reg_wdata_in[`ILMP_MODE_FSEL_HI:`ILMP_MODE_FSEL_LO];
            end
        end
    end

    // strobe uses the next enable so it drops on the acknowledge edge
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            irq_req_ff <= 1'b0;
            irq_level_ff <= `ILMP_RST_LVL;
            irq_fast_ff <= 1'b0;
            level_live_ff <= `ILMP_RST_BYTE;
            rdata_ff <= `ILMP_RST_BYTE;
        end
        else
        begin
            irq_req_ff <= nxt_gie && win_vld;
            irq_level_ff <= win_lvl;
            irq_fast_ff <= nxt_gie && win_vld && nxt_fast;
            level_live_ff <= live;
            if (reg_rd_in)
                rdata_ff <= rd_mux;
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign irq_req_out = irq_req_ff;
    assign irq_level_out = irq_level_ff;
    assign irq_fast_out = irq_fast_ff;
    assign level_live_out = level_live_ff;

endmodule

// ### core/ilmp_defs.svh
// register offsets, field positions and codes of the interrupt level block
`ifndef ILMP_DEFS_SVH
`define ILMP_DEFS_SVH

`define ILMP_OFS_MASK 8'hdd
`define ILMP_OFS_MODE 8'hde
`define ILMP_OFS_PRIO 8'hff
`define ILMP_PRIO_BANK 1'b0

`define ILMP_MODE_GIE 0
`define ILMP_MODE_FIE 1
`define ILMP_MODE_FSEL_LO 2
`define ILMP_MODE_FSEL_HI 4

`define ILMP_PRIO_A_SWAP 0
`define ILMP_PRIO_GRP_LO 1
`define ILMP_PRIO_B_ORDER 2
`define ILMP_PRIO_B_SWAP 3
`define ILMP_PRIO_GRP_MID 4
`define ILMP_PRIO_C_ORDER 5
`define ILMP_PRIO_C_SWAP 6
`define ILMP_PRIO_GRP_HI 7

`define ILMP_GORD_BCA 3'h1
`define ILMP_GORD_ABC 3'h2
`define ILMP_GORD_BAC 3'h3
`define ILMP_GORD_CAB 3'h4
`define ILMP_GORD_CBA 3'h5
`define ILMP_GORD_ACB 3'h6

`define ILMP_RST_BYTE 8'h00
`define ILMP_RST_FSEL 3'h0
`define ILMP_RST_LVL 3'h0
`define ILMP_RSVD_MODE 3'h0
`define ILMP_GRP_SUM 2'h3

`define ILMP_LVL0 3'h0
`define ILMP_LVL1 3'h1
`define ILMP_LVL2 3'h2
`define ILMP_LVL3 3'h3
`define ILMP_LVL4 3'h4
`define ILMP_LVL5 3'h5
`define ILMP_LVL6 3'h6
`define ILMP_LVL7 3'h7

`endif

// ### core/ilmp_pkg.sv
// shared types of the interrupt level block
package ilmp_pkg;

    typedef enum logic [1:0] {
        ilmp_grp_a,
        ilmp_grp_b,
        ilmp_grp_c
    } ilmp_grp_e;

    typedef logic [7:0] ilmp_byte_t;
    typedef logic [2:0] ilmp_lvl_t;

endpackage

// ### core/ilmp_grp_pick.sv
// winner of one priority group: one single level against an ordered pair
`timescale 1ns/1ps

module ilmp_grp_pick
    import ilmp_pkg::*;
#(
    parameter ilmp_lvl_t LVL_SINGLE = 3'h0,
    parameter ilmp_lvl_t LVL_PAIR_HI = 3'h0,
    parameter ilmp_lvl_t LVL_PAIR_LO = 3'h0
)
(
    input wire logic single_req_in,
    input wire logic pair_hi_req_in,
    input wire logic pair_lo_req_in,
    input wire logic pair_first_in,
    input wire logic pair_swap_in,
    output logic win_vld_out,
    output ilmp_lvl_t win_lvl_out
);

    wire pair_vld;
    wire ilmp_lvl_t pair_lvl;
    wire pair_lo_first;

    // swap bit flips the pair; the lower level leads by default
    assign pair_lo_first = pair_swap_in ? !pair_hi_req_in : pair_lo_req_in;
    assign pair_vld = pair_hi_req_in || pair_lo_req_in;
    assign pair_lvl = pair_lo_first ? LVL_PAIR_LO : LVL_PAIR_HI;

    assign win_vld_out = single_req_in || pair_vld;
    assign win_lvl_out = (pair_vld && (pair_first_in || !single_req_in)) ? pair_lvl
                                                                          : LVL_SINGLE;

endmodule

// ### dv/ilmp_ctrl_properties.sv
// port-level assertions for the interrupt level block
`timescale 1ns/1ps
module ilmp_ctrl_properties
    import ilmp_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_bank_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic global_irq_on_instr_in,
    input wire logic global_irq_off_instr_in,
    input wire logic handler_return_instr_in,
    input wire logic irq_ack_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic irq_req_out,
    input wire logic [2:0] irq_level_out,
    input wire logic [7:0] level_live_out
);
    default clocking dc @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    wire logic on_any = global_irq_on_instr_in | handler_return_instr_in;
    wire logic mode_rd = reg_rd_in && reg_addr_in == 8'hde;
    wire logic hit = reg_addr_in == 8'hdd || reg_addr_in == 8'hde;
    wire logic unm_rd = reg_rd_in && !(hit || (reg_addr_in == 8'hff && !reg_bank_in));

    a_ack_drops_req: assert property (irq_ack_in |=> !irq_req_out)
        else $error("strobe kept after acknowledge");
    a_ack_stays_off: assert property (irq_ack_in ##1 !(on_any || reg_wr_in) |=> !irq_req_out)
        else $error("strobe back without re-enable");
    a_off_drops_req: assert property (global_irq_off_instr_in |=> !irq_req_out)
        else $error("strobe kept after disable");
    a_on_raises_req: assert property ($past(on_any) && !$past(irq_ack_in)
        && !$past(global_irq_off_instr_in) |-> irq_req_out == (|level_live_out))
        else $error("strobe does not follow enable");
    a_req_is_live: assert property (irq_req_out |-> level_live_out[irq_level_out])
        else $error("winner not a live level");
    a_rdata_stands: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
        else $error("read data moved without read");
    a_mode_rsvd_zero: assert property ($past(mode_rd) |-> reg_rdata_out[7:5] == 3'h0)
        else $error("mode upper bits not zero");
    a_unmapped_zero: assert property ($past(unm_rd) |-> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule

// ### dv/ilmp_cpu_model.sv
// cpu core model: acknowledges the strobe after a chosen wait
`timescale 1ns/1ps
module ilmp_cpu_model
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic irq_req_in,
    input wire logic [2:0] irq_level_in,
    input wire logic ack_en_in,
    input wire logic [1:0] delay_in,
    output logic irq_ack_out,
    output logic [2:0] ack_level_out
);
    logic [1:0] wait_ff;
    // falling edge drive keeps the acknowledge settled at the sampling edge
    always @(negedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            irq_ack_out <= 1'b0;
            wait_ff <= 2'h0;
        end
        else if (irq_ack_out)
            irq_ack_out <= 1'b0;
        else if (irq_req_in && ack_en_in && wait_ff >= delay_in)
        begin
            irq_ack_out <= 1'b1;
            ack_level_out <= irq_level_in;
            wait_ff <= 2'h0;
        end
        else
            wait_ff <= (irq_req_in && ack_en_in) ? wait_ff + 2'h1 : 2'h0;
    end
endmodule

// ### dv/test_interrupt_level_mask_priority.sv
// self-checking bench for the interrupt level block
`timescale 1ns/1ps
module test_interrupt_level_mask_priority import ilmp_pkg::*;;
    logic clock_in = 0, reset_in = 1, wr = 0, rd = 0, bank = 0, ack_en = 0, rd_seen = 0;
    logic [7:0] addr = 0, wdata = 0, req = 0, src = 0, rdata, live;
    logic [2:0] instr = 0, lvl, alvl;
    logic [1:0] dly = 0;
    logic irq_req, ack;
    logic fast;
    logic fast_hold = 1'b0;
    logic [7:0] mode_w = 8'h00;
    logic [3:0] note;
    logic [31:0] seed = 32'ha44467e1;
    logic [7:0] rq[$];
    logic [3:0] lq[$];
    int n_errors = 0, comparisons = 0, n_acks = 0, t;
    // prio, mask, src enable, request, expected winner
    logic [35:0] rows [18] = '{36'h02ffff235, 36'h02ffff272, 36'h82ffff275,
        36'h10ffff270, 36'h11ffff031, 36'h80ffffe05, 36'ha0ffffe06,
        36'he0ffffe07, 36'h10ffff1c2, 36'h14ffff1c3, 36'h1cffff1c4,
        36'h12ffff810, 36'h90ffff847, 36'h80ffff050, 36'h10feff031,
        36'h10fffd030, 36'h00ffff842, 36'h92ffff842};
    ilmp_ctrl dut (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(addr),
        .reg_bank_in(bank), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
        .global_irq_on_instr_in(instr[0]), .global_irq_off_instr_in(instr[1]),
        .handler_return_instr_in(instr[2]), .irq_ack_in(ack), .level_req_in(req),
        .level_src_en_in(src), .reg_rdata_out(rdata), .irq_req_out(irq_req),
        .irq_level_out(lvl), .irq_fast_out(fast), .level_live_out(live));
    ilmp_cpu_model cpu (.clock_in(clock_in), .reset_in(reset_in), .irq_req_in(irq_req),
        .irq_level_in(lvl), .ack_en_in(ack_en), .delay_in(dly), .irq_ack_out(ack),
        .ack_level_out(alvl));
    initial forever #2 clock_in = ~clock_in;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic b, input logic [7:0] d);
        @(negedge clock_in);
        addr = a;
        bank = b;
        wdata = d;
        if (w)
            wr = 1;
        else
        begin
            rd = 1;
            rq.push_back(d);
        end
        @(negedge clock_in);
        wr = 0;
        rd = 0;
    endtask
    task automatic pulse(input int i);
        @(negedge clock_in);
        instr[i] = 1'b1;
        @(negedge clock_in);
        instr = 3'h0;
    endtask
    task automatic final_report();
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clock_in) rd_seen <= rd;
    always @(negedge clock_in)
    begin
        if (rd_seen)
            chk("reg_rdata_out", rq.pop_front(), rdata);
        if (ack)
        begin
            n_acks++;
            note = lq.pop_front();
            chk("irq_level_out", {5'h0, note[2:0]}, {5'h0, alvl});
            chk("irq_fast_out", {7'h0, note[3]}, {7'h0, fast_hold});
        end
    end
    // fast flag only means something while the strobe stands
    always @(negedge clock_in)
        if (irq_req)
            fast_hold <= fast;
    initial
    begin
        repeat (4000) @(posedge clock_in);
        n_errors++;
        final_report();
    end
    initial
    begin
        repeat (8) @(posedge clock_in);
        @(negedge clock_in);
        reset_in = 0;
        acc(0, 8'hdd, 0, 8'h00);
        acc(0, 8'hde, 0, 8'h00);
        acc(0, 8'hff, 0, 8'h00);
        acc(0, 8'hdc, 0, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            acc(1, 8'hdd, 0, seed[7:0]);
            acc(0, 8'hdd, 0, seed[7:0]);
        end
        acc(1, 8'hde, 0, 8'hff);
        acc(0, 8'hde, 0, 8'h1f);
        acc(1, 8'hde, 0, 8'h00);
        acc(1, 8'hff, 0, 8'h5a);
        acc(1, 8'hff, 1, 8'ha5);
        acc(0, 8'hff, 1, 8'h00);
        acc(0, 8'hff, 0, 8'h5a);
        req = 8'hff;
        src = 8'hff;
        pulse(0);
        pulse(1);
        ack_en = 1;
        foreach (rows[i])
        begin
            seed = lfsr(seed);
            dly = seed[1:0];
            // rows with index bit 1 clear aim the fast level at the winner; odd rows always enable fast; fields set while disabled
            mode_w = {3'h0, i[1] ? seed[6:4] : rows[i][2:0], i[0] | seed[3], 1'b0};
            acc(1, 8'hff, 0, rows[i][35:28]);
            acc(1, 8'hdd, 0, rows[i][27:20]);
            acc(1, 8'hde, 0, mode_w);
            src = rows[i][19:12];
            req = rows[i][11:4];
            lq.push_back({(mode_w[1] && (mode_w[4:2] == rows[i][2:0])), rows[i][2:0]});
            t = n_acks;
            if (i % 3 == 0)
                pulse(2);
            else if (i % 3 == 1)
                pulse(0);
            else
                acc(1, 8'hde, 0, mode_w | 8'h01);
            for (int k = 0; k < 30 && n_acks == t; k++) @(posedge clock_in);
        end
        chk("ack count", 8'h12, n_acks[7:0]);
        final_report();
    end
endmodule
bind ilmp_ctrl ilmp_ctrl_properties chk_props (.clock_in, .reset_in, .reg_addr_in,
    .reg_bank_in, .reg_wr_in, .reg_rd_in, .global_irq_on_instr_in, .global_irq_off_instr_in,
    .handler_return_instr_in, .irq_ack_in, .reg_rdata_out, .irq_req_out, .irq_level_out,
    .level_live_out);
